// ### verilog/clocked_serial_slave_busy_handshake.v
/*
   Slave end of a clocked serial channel selected by an active-low select
   line, with a BUSY handshake pin and an APB register port.
   Assumes select, serial clock and serial data in are asynchronous pins,
   sampled on clk (10 MHz); the serial clock is far slower than clk.
*/
// Added by the designer: the register addresses and the APB slave port.
// Overview of operation
// - A select edge that reads low marks the device selected and starts the channel.
// - A select edge that reads high marks the device deselected and stops the channel.
// - On a single-character buffer-empty event BUSY goes high, timing moves to end of transfer.
// - On single transfer end the byte is held, timing returns to buffer empty, handler too.
// - In continuous reception each receive-end event writes the byte at the current position.
// - When the remaining count is one the last-data handler is chosen for the next event.
// - BUSY goes high as the final character of continuous reception begins.
// - Characters are eight bits, most significant first, clock type 1.
// - Both edges of the select input raise a select event.
// - Deselection releases the data output, pulses BUSY then releases it, stops, and clears count, handler and timing.
`timescale 1ns/100ps
`default_nettype none
`include "serial_slave_regs.vh"

module clocked_serial_slave_busy_handshake
#(
   parameter ADDR_W = 4
)
(
   input wire clk,
   input wire reset,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire selectInputN,
   input wire serialClk,
   input wire serialDataIn,
   output wire serialDataOutput,
   output reg serialDataOeN,
   output reg busyOut,
   output reg busyOeN
);

   // ==========================================================
   // Pin synchronisers
   reg [2:0] selSync_q;
   reg [2:0] clkSync_q;
   reg [1:0] dinSync_q;

   always @(posedge clk)
   begin
      if (reset)
      begin
         selSync_q <= 3'h7;
         clkSync_q <= 3'h7;
         dinSync_q <= 2'h0;
      end
      else
      begin
         selSync_q <= {selSync_q[1:0], selectInputN};
         clkSync_q <= {clkSync_q[1:0], serialClk};
         dinSync_q <= {dinSync_q[0], serialDataIn};
      end
   end

   wire selLevel = selSync_q[1];
   wire selectEdgeEvent = selSync_q[1] ^ selSync_q[2];
   wire sclkRise = clkSync_q[1] & ~clkSync_q[2];
   wire sclkFall = ~clkSync_q[1] & clkSync_q[2];

   // ==========================================================
   // State
   reg running_q;
   reg streamMode_q;
   reg eventAtEnd_q;
   reg [3:0] handlerSelector_q;
   reg [7:0] remainingCount_q;
   reg [7:0] singleRxByte_q;
   reg [7:0] txData_q;
   reg [7:0] txShift_q;
   reg [7:0] rxShift_q;
   reg [3:0] bitCnt_q;
   reg [ADDR_W-1:0] wrPos_q;
   reg [ADDR_W-1:0] bufIdx_q;
   reg lastArmed_q;
   reg releasePend_q;

   wire [7:0] rxNext = {rxShift_q[6:0], dinSync_q[1]};
   wire charStart = running_q & sclkFall & (bitCnt_q == 4'h0);
   wire charEnd = running_q & sclkRise & (bitCnt_q == `CHAR_BITS - 4'h1);
   wire channelEvent = eventAtEnd_q ? charEnd : charStart;
   wire memWr = channelEvent & streamMode_q &
      ((handlerSelector_q == `H_STREAM_RX) | (handlerSelector_q == `H_LAST_RX));
   wire [7:0] bufData;

   wire apbWrite = psel & penable & pwrite;
   wire wrCtrl = apbWrite & (paddr == `REG_CTRL);

   function mapped;
      input [7:0] a;
      begin
         mapped = (a == `REG_CTRL) | (a == `REG_COUNT) | (a == `REG_STATUS) |
            (a == `REG_SINGLE_RX) | (a == `REG_TXDATA) | (a == `REG_BUFIDX) |
            (a == `REG_BUFDATA);
      end
   endfunction

   // ==========================================================
   // Shift engine
   always @(posedge clk)
   begin
      if (reset | ~running_q)
      begin
         bitCnt_q <= 4'h0;
         txShift_q <= 8'h00;
         rxShift_q <= 8'h00;
      end
      else
      begin
         // Type 1: out on falling, in on rising, MSB first
         if (sclkFall)
         begin
            txShift_q <= (bitCnt_q == 4'h0) ? txData_q : {txShift_q[6:0], 1'b0};
         end
         if (sclkRise)
         begin
            rxShift_q <= rxNext;
            bitCnt_q <= charEnd ? 4'h0 : bitCnt_q + 4'h1;
         end
      end
   end

   assign serialDataOutput = txShift_q[7];

   // ==========================================================
   // Selection and event dispatch
   always @(posedge clk)
   begin
      if (reset)
      begin
         running_q <= 1'b0;
         eventAtEnd_q <= 1'b0;
         handlerSelector_q <= `H_BUF_EMPTY;
         remainingCount_q <= `RST_COUNT;
         singleRxByte_q <= 8'h00;
         wrPos_q <= {ADDR_W{1'b0}};
         lastArmed_q <= 1'b0;
         releasePend_q <= 1'b0;
         busyOut <= 1'b0;
         busyOeN <= 1'b1;
         serialDataOeN <= 1'b1;
      end
      else if (selectEdgeEvent & ~selLevel)
      begin
         // Stream mode starts straight on receive-end timing
         running_q <= 1'b1;
         serialDataOeN <= 1'b0;
         busyOut <= 1'b0;
         busyOeN <= 1'b0;
         wrPos_q <= {ADDR_W{1'b0}};
         eventAtEnd_q <= streamMode_q;
         lastArmed_q <= streamMode_q & (remainingCount_q == 8'h01);
         if (~streamMode_q)
            handlerSelector_q <= `H_BUF_EMPTY;
         else if (remainingCount_q == 8'h01)
            handlerSelector_q <= `H_LAST_RX;
         else
            handlerSelector_q <= `H_STREAM_RX;
      end
      else if (selectEdgeEvent & selLevel)
      begin
         running_q <= 1'b0;
         busyOut <= 1'b1;
         releasePend_q <= 1'b1;
         serialDataOeN <= 1'b1;
         eventAtEnd_q <= 1'b0;
         handlerSelector_q <= `H_BUF_EMPTY;
         remainingCount_q <= 8'h00;
         lastArmed_q <= 1'b0;
      end
      else
      begin
         if (releasePend_q)
         begin
            // BUSY was shown high for one cycle before the pin is let go
            busyOeN <= 1'b1;
            busyOut <= 1'b0;
            releasePend_q <= 1'b0;
         end
         if (wrCtrl & pwdata[`CTRL_BUSY_RELEASE] & running_q)
            busyOut <= 1'b0;
         if (apbWrite & (paddr == `REG_COUNT) & ~running_q)
            remainingCount_q <= pwdata[7:0];
         if (charStart & lastArmed_q)
         begin
            busyOut <= 1'b1;
            lastArmed_q <= 1'b0;
         end
         if (channelEvent)
         begin
            case (handlerSelector_q)
               `H_BUF_EMPTY:
               begin
                  busyOut <= 1'b1;
                  eventAtEnd_q <= 1'b1;
                  handlerSelector_q <= `H_XFER_END;
               end
               `H_XFER_END:
               begin
                  singleRxByte_q <= rxNext;
                  eventAtEnd_q <= 1'b0;
                  handlerSelector_q <= `H_BUF_EMPTY;
               end
               `H_STREAM_RX:
               begin
                  wrPos_q <= wrPos_q + {{(ADDR_W-1){1'b0}}, 1'b1};
                  remainingCount_q <= remainingCount_q - 8'h01;
                  if (remainingCount_q == 8'h02)
                  begin
                     handlerSelector_q <= `H_LAST_RX;
                     lastArmed_q <= 1'b1;
                  end
               end
               `H_LAST_RX:
               begin
                  wrPos_q <= wrPos_q + {{(ADDR_W-1){1'b0}}, 1'b1};
                  remainingCount_q <= 8'h00;
               end
               default:
               begin
                  handlerSelector_q <= `H_BUF_EMPTY;
               end
            endcase
         end
      end
   end

   rx_buffer_mem #(.WIDTH(8), .ADDR_W(ADDR_W)) buffer
   (
      .clk(clk),
      .wrEn(memWr),
      .wrAddr(wrPos_q),
      .wrData(rxNext),
      .rdAddr(bufIdx_q),
      .rdData(bufData)
   );

   // ==========================================================
   // APB slave: read data captured in setup, zero wait states
   always @(posedge clk)
   begin
      if (reset)
      begin
         streamMode_q <= 1'b0;
         txData_q <= `RST_TXDATA;
         bufIdx_q <= {ADDR_W{1'b0}};
         prdata <= 32'h00000000;
      end
      else
      begin
         // Mode is frozen while selected so a frame keeps one meaning
         if (wrCtrl & ~running_q)
            streamMode_q <= pwdata[`CTRL_STREAM];
         if (apbWrite & (paddr == `REG_TXDATA))
            txData_q <= pwdata[7:0];
         if (apbWrite & (paddr == `REG_BUFIDX))
            bufIdx_q <= pwdata[ADDR_W-1:0];
         if (psel & ~penable)
         begin
            case (paddr)
               `REG_CTRL: prdata <= {31'h00000000, streamMode_q};
               `REG_COUNT: prdata <= {24'h000000, remainingCount_q};
               `REG_STATUS: prdata <= {24'h000000, handlerSelector_q, 1'b0,
                  eventAtEnd_q, busyOut, running_q};
               `REG_SINGLE_RX: prdata <= {24'h000000, singleRxByte_q};
               `REG_TXDATA: prdata <= {24'h000000, txData_q};
               `REG_BUFIDX: prdata <= {{(32-ADDR_W){1'b0}}, bufIdx_q};
               `REG_BUFDATA: prdata <= {24'h000000, bufData};
               default: prdata <= 32'h00000000;
            endcase
         end
      end
   end

   assign pready = psel & penable;
   assign pslverr = psel & penable & ~mapped(paddr);

endmodule

`default_nettype wire

// ### verilog/serial_slave_regs.vh
/*
   Register map, field positions, reset values and handler codes of the
   clocked serial slave. Assumes it is included by bare name from verilog/.
*/
`ifndef SERIAL_SLAVE_REGS_VH
`define SERIAL_SLAVE_REGS_VH

// ==========================================================
// Register offsets (byte addresses)
`define REG_CTRL 8'h00
`define REG_COUNT 8'h04
`define REG_STATUS 8'h08
`define REG_SINGLE_RX 8'h0c
`define REG_TXDATA 8'h10
`define REG_BUFIDX 8'h14
`define REG_BUFDATA 8'h18

// ==========================================================
// Fields
`define CTRL_STREAM 0
`define CTRL_BUSY_RELEASE 1
`define ST_SELECTED 0
`define ST_BUSY 1
`define ST_EVT_AT_END 2
`define ST_HANDLER_LSB 4
`define ST_HANDLER_MSB 7

// ==========================================================
// Handler selector codes, one-hot
`define H_BUF_EMPTY 4'h1
`define H_XFER_END 4'h2
`define H_STREAM_RX 4'h4
`define H_LAST_RX 4'h8

// ==========================================================
// Reset values and character size
`define RST_TXDATA 8'hff
`define RST_COUNT 8'h00
`define CHAR_BITS 4'h8

`endif

// ### verilog/rx_buffer_mem.v
/*
   Destination buffer for continuous reception: one write port, one read
   port whose data come out of a register. Single clock domain.
*/
`timescale 1ns/100ps
`default_nettype none

module rx_buffer_mem
#(
   parameter WIDTH = 8,
   parameter ADDR_W = 4
)
(
   input wire clk,
   input wire wrEn,
   input wire [ADDR_W-1:0] wrAddr,
   input wire [WIDTH-1:0] wrData,
   input wire [ADDR_W-1:0] rdAddr,
   output reg [WIDTH-1:0] rdData
);

   reg [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

   always @(posedge clk)
   begin
      if (wrEn)
      begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end

endmodule

`default_nettype wire

// ### dv/serial_slave_checker_assertions.sv
/* Port checker for the serial slave.
   Assumes binding to the top module, one clock, sync reset. */
`timescale 1ns/100ps
`default_nettype none
module serial_slave_checker (
   input wire clk,
   input wire reset,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire selectInputN,
   input wire serialClk,
   input wire serialDataOutput,
   input wire serialDataOeN,
   input wire busyOut,
   input wire busyOeN
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // ====
   // Link pins
   a_busy_pulse: assert property ($rose(busyOeN) |-> $past(busyOut) && !busyOut)
      else $error("busy released without a high pulse");
   a_busy_idle_low: assert property (busyOeN |-> !busyOut)
      else $error("busy high while undriven");
   a_deselect_release: assert property ($rose(selectInputN) |-> ##[1:8] serialDataOeN && busyOeN)
      else $error("pins not released after deselect");
   a_idle_quiet: assert property (selectInputN [*8] |-> serialDataOeN && busyOeN)
      else $error("pin driven while deselected");
   a_busy_holds: assert property (busyOut && !busyOeN && !selectInputN
      && !(psel && pwrite && paddr == 8'h00) |=> busyOut)
      else $error("busy dropped on its own");
   a_out_on_fall: assert property (!serialDataOeN && !$past(serialDataOeN)
      && $changed(serialDataOutput) |-> !serialClk)
      else $error("data out changed with clock high");
   // ====
   // Register port
   a_err_in_access: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
   a_no_wait: assert property (psel && penable |-> pready)
      else $error("access phase stalled");
   a_read_stands: assert property (psel && penable |=> $stable(prdata))
      else $error("read data moved after access");
endmodule
bind clocked_serial_slave_busy_handshake serial_slave_checker u_chk (.clk(clk), .reset(reset),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .selectInputN(selectInputN), .serialClk(serialClk),
   .serialDataOutput(serialDataOutput), .serialDataOeN(serialDataOeN), .busyOut(busyOut),
   .busyOeN(busyOeN));
`default_nettype wire

// ### dv/serial_master_model.sv
/* Serial master model: select, clock idling high, data MSB first.
   Assumes BUSY and data-in pins resolved by the bench. */
`timescale 1ns/100ps
`default_nettype none
module serial_master_model (
   output logic selN,
   output logic sclk,
   output logic mosi,
   input wire logic miso,
   input wire logic busy
);
   initial
   begin
      selN = 1'b1;
      sclk = 1'b1;
      mosi = 1'b0;
   end
   // ====
   // Offset keeps the link out of phase with clk
   task select(input logic lvl);
      #230 selN = lvl;
      #1600;
   endtask
   task xfer(input logic [7:0] tx, output logic [7:0] rx);
      while (busy)
         #100;
      // Off the clk edges so the pins never race the synchronisers
      #30;
      for (int i = 7; i >= 0; i--)
      begin
         #400 sclk = 1'b0;
         mosi = tx[i];
         #400 sclk = 1'b1;
         rx[i] = miso;
      end
      // Stale data must not look valid
      #400 mosi = ~mosi;
   endtask
endmodule
`default_nettype wire

// ### dv/tb_top.sv
/* Self-checking bench for the serial slave.
   Assumes pull-down on BUSY and pull-up on data out. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic clk, reset, psel, penable, pwrite, lastErr;
   logic [7:0] paddr, rx;
   logic [31:0] pwdata, rd, prdata;
   logic pready, pslverr, sdo, sdoOeN, busyOut, busyOeN, selN, sclk, mosi;
   int fail_count = 0;
   int samples_checked = 0;
   logic [40:0] rows [0:5] = '{{1'b0, 8'h00, 32'h0}, {1'b0, 8'h04, 32'h0},
      {1'b0, 8'h08, 32'h10}, {1'b0, 8'h10, 32'hff}, {1'b0, 8'h14, 32'h0}, {1'b1, 8'h1c, 32'h0}};
   wire busyPin = busyOeN ? 1'b0 : busyOut;
   wire misoPin = sdoOeN ? 1'b1 : sdo;
   clocked_serial_slave_busy_handshake u_clocked_serial_slave_busy_handshake (.clk(clk),
      .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .selectInputN(selN), .serialClk(sclk), .serialDataIn(mosi), .serialDataOutput(sdo),
      .serialDataOeN(sdoOeN), .busyOut(busyOut), .busyOeN(busyOeN));
   serial_master_model u_serial_master_model (.selN(selN), .sclk(sclk), .mosi(mosi),
      .miso(misoPin), .busy(busyPin));
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // ====
   // Bus master
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task wrap_up;
      if (fail_count == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      #200000;
      fail_count++;
      wrap_up;
   end
   initial
   begin
      reset = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      foreach (rows[i])
      begin
         rdchk(rows[i][39:32], rows[i][31:0]);
         chk({31'h0, lastErr}, {31'h0, rows[i][40]});
      end
      apb(1'b1, 8'h10, 32'ha5);
      u_serial_master_model.select(1'b0);
      rdchk(8'h08, 32'h11);
      fork
         u_serial_master_model.xfer(8'h3c, rx);
         begin
            repeat (30) @(posedge clk);
            rdchk(8'h08, 32'h27);
         end
      join
      chk({24'h0, rx}, 32'ha5);
      rdchk(8'h08, 32'h13);
      rdchk(8'h0c, 32'h3c);
      apb(1'b1, 8'h00, 32'h2);
      u_serial_master_model.xfer(8'hc3, rx);
      rdchk(8'h0c, 32'hc3);
      u_serial_master_model.select(1'b1);
      rdchk(8'h08, 32'h10);
      apb(1'b1, 8'h00, 32'h1);
      apb(1'b1, 8'h04, 32'h3);
      u_serial_master_model.select(1'b0);
      u_serial_master_model.xfer(8'h11, rx);
      u_serial_master_model.xfer(8'h22, rx);
      rdchk(8'h08, 32'h85);
      chk({31'h0, busyPin}, 32'h0);
      u_serial_master_model.xfer(8'h33, rx);
      chk({31'h0, busyPin}, 32'h1);
      rdchk(8'h04, 32'h0);
      for (int i = 0; i < 3; i++)
      begin
         apb(1'b1, 8'h14, i);
         repeat (2) @(posedge clk);
         rdchk(8'h18, 32'h11 * (i + 1));
      end
      u_serial_master_model.select(1'b1);
      // One-character stream starts on the last-data handler
      apb(1'b1, 8'h04, 32'h1);
      u_serial_master_model.select(1'b0);
      rdchk(8'h08, 32'h85);
      u_serial_master_model.xfer(8'h44, rx);
      chk({31'h0, busyPin}, 32'h1);
      apb(1'b1, 8'h14, 32'h0);
      repeat (2) @(posedge clk);
      rdchk(8'h18, 32'h44);
      u_serial_master_model.select(1'b1);
      // Reset while deselected brings control, status and transmit data back to idle
      apb(1'b1, 8'h10, 32'h5a);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      chk({30'h0, sdoOeN, busyOeN}, 32'h3);
      reset <= 1'b0;
      rdchk(8'h00, 32'h0);
      rdchk(8'h08, 32'h10);
      rdchk(8'h10, 32'hff);
      wrap_up;
   end
endmodule
`default_nettype wire
